// ===== design/dcs_defines.svh
// Behaviour
// R1: two-channel switching only when both channel-element bits of the register are set.
// R2: with the switch neutral, the first channel issuing a standard command gets connected.
// R3: connection holds until channel end, then the switch returns to neutral.
// R4: system reset or a set-configuration transfer breaks any channel connection.
// R5: a command from the unconnected channel is answered with control unit busy.
// R6: after the connection breaks, each busied channel gets control unit end; a break by system reset clears the pending ends instead.
// R7: computing element loads the register bit-parallel; the unit loads from that transfer.
// R8: a transfer with correct parity is acknowledged back to the computing element.
// R9: register parity is checked continuously; error raises element check and sense bit 2.
// R10: in states one to three an all-zero source field accepts any element.
// R11: reset gives state bits zero, source bits all ones, channel bits all zeros.
// R12: the register is reset only by power-on reset or system reset.
// R13: states one to three enable both interfaces, disable diagnostics and all manual controls.
// R14: state zero normal/inline enable interfaces, diagnostics, test switch; inline adds micro-diag.
// R15: state zero test position isolates interfaces, ignores external control, enables manual and power.
// R16: over-current or normal power-off raises element check interruption.
// R17: thermal check level sends a pulsed element check and sets sense bit 3.
// R18: state indicators decode state bits 11, 10, 01, 00 as three, two, one, zero.
// R19: a transfer with bad parity gets no acknowledgement.
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH
// configuration register layout, odd parity over all nine bits
`define DCS_CCR_W 9
`define DCS_ST_LSB 0
`define DCS_ST_MSB 1
`define DCS_SRC_LSB 2
`define DCS_SRC_MSB 5
`define DCS_CH_LSB 6
`define DCS_CH_MSB 7
`define DCS_PAR_BIT 8
`define DCS_CCR_RST 9'h13c
// sense byte 4 bit positions
`define DCS_SNS_PAR 2
`define DCS_SNS_THM 3
// interrupt event bits
`define DCS_EV_W 6
`define DCS_EV_PAR 0
`define DCS_EV_OVC 1
`define DCS_EV_PWR 2
`define DCS_EV_THM 3
`define DCS_EV_SET_CONFIGURATION_TRANSFER 4
`define DCS_EV_BUSY 5
// register byte offsets
`define DCS_A_CCR 8'h00
`define DCS_A_STS 8'h04
`define DCS_A_MASK 8'h08
`define DCS_A_SNS 8'h0c
`define DCS_A_SW 8'h10
`define DCS_RESP_OK 2'h0
`define DCS_RESP_ERR 2'h2
`endif

// ===== design/dcs_pkg.sv
package dcs_pkg;
  // channel switch position
  typedef enum logic [1:0] {SW_NEUTRAL, SW_CH0, SW_CH1} dcs_sw_t;
  // maintenance selector position
  typedef enum logic [1:0] {MT_NORMAL, MT_INLINE, MT_TEST, MT_SPARE} dcs_maint_t;
endpackage : dcs_pkg

// ===== design/dcs_sync2.sv
`timescale 1ns/1ns
module dcs_sync2 #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  // two stages; the first is read only by the second
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end
  assign syncOut = sync_ff;
endmodule : dcs_sync2

// ===== design/dcs_state_ctl.sv
`timescale 1ns/1ns
module dcs_state_ctl (
  input wire logic [1:0] stateBits,
  input wire dcs_pkg::dcs_maint_t maintMode,
  output logic ioIfEn,
  output logic ceIfEn,
  output logic diagEn,
  output logic testSwEn,
  output logic manualEn,
  output logic microDiagEn,
  output logic powerSwEn,
  output logic [3:0] stateInd
);
  import dcs_pkg::*;
  // enable decode per state and selector position
  always_comb begin
    ioIfEn = 1'b1;
    ceIfEn = 1'b1;
    diagEn = 1'b0; // R13
    testSwEn = 1'b0;
    manualEn = 1'b0;
    microDiagEn = 1'b0;
    powerSwEn = 1'b0;
    if (stateBits == 2'h0) begin
      diagEn = 1'b1; // R14
      testSwEn = 1'b1;
      case (maintMode)
        MT_INLINE: begin
          microDiagEn = 1'b1; // R14
        end
        MT_TEST: begin
          ioIfEn = 1'b0; // R15
          ceIfEn = 1'b0;
          manualEn = 1'b1;
          microDiagEn = 1'b1;
          powerSwEn = 1'b1;
        end
        default: begin
          microDiagEn = 1'b0;
        end
      endcase
    end
  end
  // one-hot console lamps, bit n lit in state n
  always_comb begin
    stateInd = 4'h0;
    stateInd[stateBits] = 1'b1; // R18
  end
endmodule : dcs_state_ctl

// ===== design/dcs_ctl.sv
`timescale 1ns/1ns
`include "dcs_defines.svh"
module dcs_ctl #(
  parameter int NUM_CE = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  // computing element side, asynchronous pins
  input wire logic sconStrobe,
  input wire logic [`DCS_CCR_W-1:0] sconData,
  input wire logic [NUM_CE-1:0] sconSrc,
  input wire logic sysResetReq,
  output logic sconAck,
  output logic elcPulse,
  // unit condition pins
  input wire logic overCurrent,
  input wire logic powerOff,
  input wire logic thermalCheck,
  input wire logic [1:0] maintSel,
  // channel side, from the unit's own channel logic
  input wire logic [1:0] chCmd,
  input wire logic chEndStatus,
  output logic [1:0] chConn,
  output logic [1:0] chAccept,
  output logic [1:0] chBusy,
  output logic [1:0] chCuEnd,
  // state control
  output logic ioIfEn,
  output logic ceIfEn,
  output logic diagEn,
  output logic testSwEn,
  output logic manualEn,
  output logic microDiagEn,
  output logic powerSwEn,
  output logic [3:0] stateInd,
  output logic [7:0] senseByte4,
  output logic irq,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import dcs_pkg::*;

  localparam int SW = `DCS_SRC_MSB - `DCS_SRC_LSB + 1;
  localparam int AW = 3 + `DCS_CCR_W + NUM_CE + 2;

  // the source field has one bit per computing element
  if (NUM_CE != SW) begin : g_bad_ce
    $error("NUM_CE must match the source field width");
  end

  // every asynchronous pin crosses two flip-flops first; channel and register bus pins do not
  logic [AW-1:0] pinSync;
  dcs_sync2 #(.W(AW)) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .asyncIn({sconStrobe, sysResetReq, thermalCheck, sconData, sconSrc, maintSel}),
    .syncOut(pinSync)
  );
  logic sStrobe;
  logic sSysRst;
  logic sThermal;
  logic [`DCS_CCR_W-1:0] sData;
  logic [NUM_CE-1:0] sSrc;
  logic [1:0] sMaint;
  assign {sStrobe, sSysRst, sThermal, sData, sSrc, sMaint} = pinSync;

  // power conditions crossed separately so their rises are visible
  logic [1:0] pwrSync;
  dcs_sync2 #(.W(2)) u_sync_pwr (
    .ref_clk(ref_clk),
    .reset(reset),
    .asyncIn({overCurrent, powerOff}),
    .syncOut(pwrSync)
  );

  logic [`DCS_CCR_W-1:0] ccr_ff, nxt_ccr;
  logic [1:0] stateBits;
  logic [SW-1:0] srcField;
  logic [1:0] chBits;
  assign stateBits = ccr_ff[`DCS_ST_MSB:`DCS_ST_LSB];
  assign srcField = ccr_ff[`DCS_SRC_MSB:`DCS_SRC_LSB];
  assign chBits = ccr_ff[`DCS_CH_MSB:`DCS_CH_LSB];

  dcs_state_ctl u_state (
    .stateBits(stateBits),
    .maintMode(dcs_maint_t'(sMaint)),
    .ioIfEn(ioIfEn),
    .ceIfEn(ceIfEn),
    .diagEn(diagEn),
    .testSwEn(testSwEn),
    .manualEn(manualEn),
    .microDiagEn(microDiagEn),
    .powerSwEn(powerSwEn),
    .stateInd(stateInd)
  );

  // edge detection on synchronised levels
  logic [4:0] prev_ff, nxt_prev;
  logic strobeRise;
  logic sysRstRise;
  logic thermRise;
  logic ovcRise;
  logic pwrRise;
  logic parErr;
  logic parRise;
  assign parErr = ~(^ccr_ff); // R9
  always_comb begin
    nxt_prev = {sStrobe, sSysRst, sThermal, pwrSync[1], pwrSync[0]};
    strobeRise = sStrobe & ~prev_ff[4];
    sysRstRise = sSysRst & ~prev_ff[3];
    thermRise = sThermal & ~prev_ff[2];
    ovcRise = pwrSync[1] & ~prev_ff[1];
    pwrRise = pwrSync[0] & ~prev_ff[0];
  end

  // configuration register load and acknowledge
  logic ack_ff, nxt_ack;
  logic sconLoad;
  logic srcOk;
  logic parPrev_ff;
  always_comb begin
    nxt_ccr = ccr_ff;
    nxt_ack = 1'b0;
    sconLoad = 1'b0;
    // an all-zero source field opens the gate to any element outside state zero
    srcOk = ((stateBits != 2'h0) && (srcField == '0)) || ((sSrc & srcField) != '0); // R10
    if (sysRstRise) begin
      nxt_ccr = `DCS_CCR_RST; // R12
    end else if (strobeRise && ceIfEn && srcOk) begin
      nxt_ccr = sData; // R7
      sconLoad = 1'b1;
      nxt_ack = ^sData; // R8 R19
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ccr_ff <= `DCS_CCR_RST; // R11
      ack_ff <= 1'b0;
      prev_ff <= 5'h00;
      parPrev_ff <= 1'b0;
    end else begin
      ccr_ff <= nxt_ccr;
      ack_ff <= nxt_ack;
      prev_ff <= nxt_prev;
      parPrev_ff <= parErr;
    end
  end
  assign parRise = parErr & ~parPrev_ff;
  assign sconAck = ack_ff;

  // channel switch
  dcs_sw_t sw_ff, nxt_sw;
  logic [1:0] pend_ff, nxt_pend;
  logic [1:0] busy_ff, nxt_busy;
  logic [1:0] cuEnd_ff, nxt_cuEnd;
  logic [1:0] acc_ff, nxt_acc;
  logic [1:0] cmdOk;
  logic twoMode;
  assign twoMode = &chBits; // R1
  // test position shuts out all channel commands
  assign cmdOk = chCmd & {2{ioIfEn}}; // R15
  always_comb begin
    nxt_sw = sw_ff;
    nxt_pend = pend_ff;
    nxt_busy = 2'h0;
    nxt_cuEnd = 2'h0;
    nxt_acc = 2'h0;
    if (!twoMode) begin
      // single-channel use: the enabled channel is always served
      nxt_sw = SW_NEUTRAL;
      nxt_acc = cmdOk & chBits;
    end else begin
      case (sw_ff)
        SW_NEUTRAL: begin
          if (cmdOk[0]) begin
            nxt_sw = SW_CH0; // R2
            nxt_acc[0] = 1'b1;
            if (cmdOk[1]) begin
              nxt_busy[1] = 1'b1; // R5
              nxt_pend[1] = 1'b1;
            end
          end else if (cmdOk[1]) begin
            nxt_sw = SW_CH1; // R2
            nxt_acc[1] = 1'b1;
          end
        end
        SW_CH0: begin
          nxt_acc[0] = cmdOk[0];
          if (cmdOk[1]) begin
            nxt_busy[1] = 1'b1; // R5
            nxt_pend[1] = 1'b1;
          end
          if (chEndStatus) begin
            nxt_sw = SW_NEUTRAL; // R3
          end
        end
        SW_CH1: begin
          nxt_acc[1] = cmdOk[1];
          if (cmdOk[0]) begin
            nxt_busy[0] = 1'b1; // R5
            nxt_pend[0] = 1'b1;
          end
          if (chEndStatus) begin
            nxt_sw = SW_NEUTRAL; // R3
          end
        end
        default: begin
          nxt_sw = SW_NEUTRAL;
        end
      endcase
    end
    if (sconLoad) begin
      nxt_sw = SW_NEUTRAL; // R4
    end
    // busied channels are told once the connection is gone
    if (nxt_sw == SW_NEUTRAL && sw_ff != SW_NEUTRAL) begin
      nxt_cuEnd = nxt_pend; // R6
      nxt_pend = 2'h0;
    end
    if (sysRstRise) begin
      nxt_sw = SW_NEUTRAL; // R4
      nxt_pend = 2'h0;
      nxt_cuEnd = 2'h0;
      nxt_busy = 2'h0;
      nxt_acc = 2'h0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sw_ff <= SW_NEUTRAL;
      pend_ff <= 2'h0;
      busy_ff <= 2'h0;
      cuEnd_ff <= 2'h0;
      acc_ff <= 2'h0;
    end else begin
      sw_ff <= nxt_sw;
      pend_ff <= nxt_pend;
      busy_ff <= nxt_busy;
      cuEnd_ff <= nxt_cuEnd;
      acc_ff <= nxt_acc;
    end
  end
  assign chConn = {sw_ff == SW_CH1, sw_ff == SW_CH0};
  assign chBusy = busy_ff;
  assign chCuEnd = cuEnd_ff;
  assign chAccept = acc_ff;

  // element check, sense byte, interrupt status
  logic elc_ff, nxt_elc;
  logic [7:0] sns_ff, nxt_sns;
  logic [`DCS_EV_W-1:0] sts_ff, nxt_sts;
  logic [`DCS_EV_W-1:0] mask_ff, nxt_mask;
  logic [`DCS_EV_W-1:0] ev;
  logic clrSts;
  logic clrSns;
  logic maskWr;
  logic [31:0] maskData;
  always_comb begin
    ev = '0;
    ev[`DCS_EV_PAR] = parRise;
    ev[`DCS_EV_OVC] = ovcRise;
    ev[`DCS_EV_PWR] = pwrRise;
    ev[`DCS_EV_THM] = thermRise;
    ev[`DCS_EV_SET_CONFIGURATION_TRANSFER] = sconLoad;
    ev[`DCS_EV_BUSY] = |nxt_busy;
    nxt_elc = parRise | ovcRise | pwrRise | thermRise; // R9 R16 R17
    // a set in the same cycle as a read-clear wins
    nxt_sns = clrSns ? 8'h00 : sns_ff;
    nxt_sns[`DCS_SNS_PAR] = nxt_sns[`DCS_SNS_PAR] | parErr; // R9
    nxt_sns[`DCS_SNS_THM] = nxt_sns[`DCS_SNS_THM] | thermRise; // R17
    nxt_sts = (clrSts ? '0 : sts_ff) | ev;
    nxt_mask = maskWr ? maskData[`DCS_EV_W-1:0] : mask_ff;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      elc_ff <= 1'b0;
      sns_ff <= 8'h00;
      sts_ff <= '0;
      mask_ff <= '0;
    end else begin
      elc_ff <= nxt_elc;
      sns_ff <= nxt_sns;
      sts_ff <= nxt_sts;
      mask_ff <= nxt_mask;
    end
  end
  assign elcPulse = elc_ff;
  assign senseByte4 = sns_ff;
  assign irq = |(sts_ff & mask_ff);

  // write channel: address and data taken in either order
  logic awHave_ff, nxt_awHave;
  logic wHave_ff, nxt_wHave;
  logic [7:0] awAddr_ff, nxt_awAddr;
  logic [31:0] wData_ff, nxt_wData;
  logic wLane0_ff, nxt_wLane0;
  logic bValid_ff, nxt_bValid;
  logic [1:0] bResp_ff, nxt_bResp;
  logic wrMapped;
  assign s_axi_awready = ~awHave_ff & ~bValid_ff;
  assign s_axi_wready = ~wHave_ff & ~bValid_ff;
  always_comb begin
    nxt_awHave = awHave_ff;
    nxt_wHave = wHave_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wData = wData_ff;
    nxt_wLane0 = wLane0_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp = bResp_ff;
    maskWr = 1'b0;
    maskData = wData_ff;
    wrMapped = (awAddr_ff[1:0] == 2'h0) && (awAddr_ff <= `DCS_A_SW);
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_awHave = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_wHave = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wLane0 = s_axi_wstrb[0];
    end
    if (awHave_ff && wHave_ff) begin
      // only the mask is writable; other mapped words ignore writes
      maskWr = (awAddr_ff == `DCS_A_MASK) && wLane0_ff;
      nxt_awHave = 1'b0;
      nxt_wHave = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp = wrMapped ? `DCS_RESP_OK : `DCS_RESP_ERR;
    end
    if (bValid_ff && s_axi_bready) begin
      nxt_bValid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0000_0000;
      wLane0_ff <= 1'b0;
      bValid_ff <= 1'b0;
      bResp_ff <= 2'h0;
    end else begin
      awHave_ff <= nxt_awHave;
      wHave_ff <= nxt_wHave;
      awAddr_ff <= nxt_awAddr;
      wData_ff <= nxt_wData;
      wLane0_ff <= nxt_wLane0;
      bValid_ff <= nxt_bValid;
      bResp_ff <= nxt_bResp;
    end
  end
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;

  // read channel: data registered at the address handshake
  logic rValid_ff, nxt_rValid;
  logic [31:0] rData_ff, nxt_rData;
  logic [1:0] rResp_ff, nxt_rResp;
  logic arTake;
  assign s_axi_arready = ~rValid_ff;
  assign arTake = s_axi_arvalid & ~rValid_ff;
  always_comb begin
    nxt_rValid = rValid_ff;
    nxt_rData = rData_ff;
    nxt_rResp = rResp_ff;
    clrSts = 1'b0;
    clrSns = 1'b0;
    if (arTake) begin
      nxt_rValid = 1'b1;
      nxt_rResp = `DCS_RESP_OK;
      nxt_rData = 32'h0000_0000;
      case (s_axi_araddr)
        `DCS_A_CCR: nxt_rData[`DCS_CCR_W-1:0] = ccr_ff;
        `DCS_A_STS: begin
          nxt_rData[`DCS_EV_W-1:0] = sts_ff;
          clrSts = 1'b1;
        end
        `DCS_A_MASK: nxt_rData[`DCS_EV_W-1:0] = mask_ff;
        `DCS_A_SNS: begin
          nxt_rData[7:0] = sns_ff;
          clrSns = 1'b1;
        end
        `DCS_A_SW: nxt_rData[5:0] = {pend_ff, twoMode, parErr, chConn};
        default: nxt_rResp = `DCS_RESP_ERR;
      endcase
    end else if (rValid_ff && s_axi_rready) begin
      nxt_rValid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rValid_ff <= 1'b0;
      rData_ff <= 32'h0000_0000;
      rResp_ff <= 2'h0;
    end else begin
      rValid_ff <= nxt_rValid;
      rData_ff <= nxt_rData;
      rResp_ff <= nxt_rResp;
    end
  end
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
endmodule : dcs_ctl

// ===== bench/dcs_ctl_checker.sv
`timescale 1ns/1ns
`include "dcs_defines.svh"
module dcs_ctl_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [1:0] chCmd,
  input wire logic chEndStatus,
  input wire logic [1:0] chConn,
  input wire logic [1:0] chAccept,
  input wire logic [1:0] chBusy,
  input wire logic [1:0] chCuEnd,
  input wire logic ioIfEn,
  input wire logic ceIfEn,
  input wire logic diagEn,
  input wire logic testSwEn,
  input wire logic manualEn,
  input wire logic powerSwEn,
  input wire logic [3:0] stateInd,
  input wire logic [7:0] senseByte4,
  input wire logic elcPulse,
  input wire logic sconAck
);
  // single domain, so clock and reset are declared once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // release is checked only on channel end cycles that carry no new command
  sequence s_endConn;
    chEndStatus && (chConn != 2'h0) && (chCmd == 2'h0);
  endsequence
  sequence s_neutral;
    chConn == 2'h0;
  endsequence
  property p_release;
    s_endConn |=> s_neutral;
  endproperty
  a_release: assert property (p_release)
    else $error("switch not neutral after channel end");
  property p_accept;
    chAccept != 2'h0 |-> ((chAccept & $past(chCmd)) == chAccept) && $onehot(chAccept);
  endproperty
  a_accept: assert property (p_accept)
    else $error("accept without command");
  property p_busy;
    chBusy != 2'h0 |-> ((chBusy & $past(chCmd)) == chBusy) && ((chBusy & chAccept) == 2'h0);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy without command");
  // control unit end only to the side that was not connected
  property p_cuEnd;
    chCuEnd != 2'h0 |-> (chConn == 2'h0) && ($past(chConn) != 2'h0)
      && (($past(chConn) & chCuEnd) == 2'h0);
  endproperty
  a_cuEnd: assert property (p_cuEnd)
    else $error("control unit end out of place");
  property p_busyStates;
    stateInd[3:1] != 3'h0 |-> ioIfEn && ceIfEn && !diagEn && !testSwEn && !manualEn && !powerSwEn;
  endproperty
  a_busyStates: assert property (p_busyStates)
    else $error("enables wrong in states one to three");
  property p_zeroOnline;
    stateInd[0] && ioIfEn |-> diagEn && testSwEn && !powerSwEn;
  endproperty
  a_zeroOnline: assert property (p_zeroOnline)
    else $error("enables wrong in state zero");
  property p_isolate;
    !ioIfEn |-> stateInd[0] && !ceIfEn && manualEn && powerSwEn;
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("test position enables wrong");
  property p_stateDec;
    $onehot(stateInd);
  endproperty
  a_stateDec: assert property (p_stateDec)
    else $error("state indicator not one-hot");
  property p_parElc;
    $rose(senseByte4[`DCS_SNS_PAR]) |-> elcPulse;
  endproperty
  a_parElc: assert property (p_parElc)
    else $error("parity sense without element check");
  property p_thmElc;
    $rose(senseByte4[`DCS_SNS_THM]) |-> elcPulse;
  endproperty
  a_thmElc: assert property (p_thmElc)
    else $error("thermal sense without element check");
  property p_ackPulse;
    sconAck |=> !sconAck;
  endproperty
  a_ackPulse: assert property (p_ackPulse)
    else $error("acknowledge longer than one cycle");
endmodule : dcs_ctl_checker

// ===== bench/dcs_far_model.sv
`timescale 1ns/1ns
module dcs_far_model (
  input wire logic ref_clk,
  output logic sconStrobe,
  output logic [8:0] sconData,
  output logic [3:0] sconSrc,
  output logic sysResetReq,
  output logic [1:0] chCmd,
  output logic chEndStatus
);
  // idle pins at time zero
  initial begin
    sconStrobe = 1'b0;
    sconData = 9'h0;
    sconSrc = 4'h0;
    sysResetReq = 1'b0;
    chCmd = 2'h0;
    chEndStatus = 1'b0;
  end
  // image steady across the strobe; scrambled once idle, since the pins float
  task automatic sendScon(input logic [8:0] img, input logic [3:0] src);
    @(posedge ref_clk);
    sconData <= img;
    sconSrc <= src;
    @(posedge ref_clk);
    sconStrobe <= 1'b1;
    repeat (6) @(posedge ref_clk);
    sconStrobe <= 1'b0;
    @(posedge ref_clk);
    sconData <= ~img;
    sconSrc <= ~src;
    repeat (4) @(posedge ref_clk);
  endtask : sendScon
  // system reset is long enough to pass the pin synchroniser
  task automatic sysRst;
    @(posedge ref_clk);
    sysResetReq <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sysResetReq <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask : sysRst
  // one-cycle channel command and channel end pulses
  task automatic chanPulse(input logic [1:0] c, input logic e);
    @(posedge ref_clk);
    chCmd <= c;
    chEndStatus <= e;
    @(posedge ref_clk);
    chCmd <= 2'h0;
    chEndStatus <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : chanPulse
endmodule : dcs_far_model

// ===== bench/dcs_ctl_tb.sv
`timescale 1ns/1ns
`include "dcs_defines.svh"
module dcs_ctl_tb;
  import dcs_pkg::*;
  logic ref_clk, reset, sconStrobe, sysResetReq, sconAck, elcPulse, chEndStatus, irq, clrSeen;
  logic ioIfEn, ceIfEn, diagEn, testSwEn, manualEn, microDiagEn, powerSwEn;
  logic [8:0] sconData;
  logic [3:0] sconSrc, stateInd, s_axi_wstrb;
  logic [2:0] evPins;
  logic [1:0] maintSel, chCmd, chConn, chAccept, chBusy, chCuEnd, s_axi_bresp, s_axi_rresp;
  logic [7:0] senseByte4, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] seen;
  int ackCnt = 0, elcCnt = 0, miscompares = 0, totalChecks = 0;
  wire [5:0] enSeen = {ioIfEn, ceIfEn, diagEn, testSwEn, microDiagEn, powerSwEn};
  dcs_far_model far (.*);
  dcs_ctl #(.NUM_CE(4)) dut (.*, .overCurrent(evPins[0]), .powerOff(evPins[1]),
    .thermalCheck(evPins[2]));
  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // pulse outputs last one cycle, so they are counted or latched here
  always @(posedge ref_clk) begin
    ackCnt <= ackCnt + int'(sconAck);
    elcCnt <= elcCnt + int'(elcPulse);
    seen <= clrSeen ? 6'h0 : (seen | {chCuEnd, chBusy, chAccept});
  end
  task automatic testDone;
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : testDone
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // write: both halves offered together, each dropped once taken
  task automatic axW(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    chk("write resp", 32'h0, s_axi_bresp);
    chk("write done", 32'h1, s_axi_bvalid);
    if (s_axi_bvalid !== 1'b1) testDone();
  endtask : axW
  task automatic axR(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    chk("read data", e, s_axi_rdata);
    chk("read resp", er, s_axi_rresp);
    chk("read done", 32'h1, s_axi_rvalid);
    if (s_axi_rvalid !== 1'b1) testDone();
  endtask : axR
  // odd parity across all nine bits when good is set
  function automatic logic [8:0] mkImg(logic [1:0] ch, logic [3:0] f, logic [1:0] s, logic good);
    logic [7:0] b;
    b = {ch, f, s};
    return {good ? ~^b : ^b, b};
  endfunction : mkImg
  function automatic logic [5:0] enExp(input logic [1:0] s, input logic [1:0] m);
    if (s != 2'h0) return 6'h30;
    if (m == 2'h2) return 6'h0f;
    return (m == 2'h1) ? 6'h3e : 6'h3c;
  endfunction : enExp
  initial begin
    logic [8:0] im;
    int a0;
    int e0;
    void'($urandom(61426));
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, maintSel, evPins} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    clrSeen = 1'b1;
    reset = 1'b1;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    axR(`DCS_A_CCR, 32'h13c, 2'h0);
    axW(`DCS_A_CCR, 32'h0);
    axR(`DCS_A_CCR, 32'h13c, 2'h0);
    axR(8'h44, 32'h0, `DCS_RESP_ERR);
    chk("state ind", 32'h1, stateInd);
    for (int m = 0; m < 4; m++) begin
      maintSel <= 2'(m + 3);
      repeat (6) @(posedge ref_clk);
      chk("maint en", enExp(2'h0, 2'(m + 3)), enSeen);
    end
    a0 = ackCnt;
    far.sendScon(mkImg(2'h3, 4'h0, 2'h1, 1'b1), 4'hf);
    chk("test ignores", a0, ackCnt);
    maintSel <= 2'h0;
    for (int s = 3; s > 0; s--) begin
      im = mkImg(2'h3, 4'h0, 2'(s), 1'b1);
      a0 = ackCnt;
      far.sendScon(im, 4'($urandom_range(15, 1)));
      chk("ack", a0 + 1, ackCnt);
      axR(`DCS_A_CCR, 32'(im), 2'h0);
      chk("state ind", 32'h1 << s, stateInd);
      chk("state en", enExp(2'(s), 2'h0), enSeen);
    end
    // a non-zero field gates out elements it does not name
    im = mkImg(2'h3, 4'h1, 2'h1, 1'b1);
    far.sendScon(im, 4'h8);
    a0 = ackCnt;
    far.sendScon(mkImg(2'h3, 4'h0, 2'h2, 1'b1), 4'h2);
    chk("gated ack", a0, ackCnt);
    axR(`DCS_A_CCR, 32'(im), 2'h0);
    e0 = elcCnt;
    far.sendScon(mkImg(2'h3, 4'h0, 2'h1, 1'b0), 4'h1);
    chk("bad ack", a0, ackCnt);
    chk("par elc", e0 + 1, elcCnt);
    chk("sense par", 32'h1, senseByte4[`DCS_SNS_PAR]);
    far.sendScon(mkImg(2'h3, 4'h0, 2'h1, 1'b1), 4'h4);
    chk("good ack", a0 + 1, ackCnt);
    axR(`DCS_A_SNS, 32'h4, 2'h0);
    repeat (2) @(posedge ref_clk);
    chk("sense clr", 32'h0, senseByte4[`DCS_SNS_PAR]);
    clrSeen <= 1'b0;
    far.chanPulse(2'h1, 1'b0);
    chk("conn0", 32'h1, chConn);
    far.chanPulse(2'h2, 1'b0);
    far.chanPulse(2'h0, 1'b1);
    chk("conn free", 32'h0, chConn);
    chk("pulses", 32'h29, seen);
    far.chanPulse(2'h2, 1'b0);
    chk("conn1", 32'h2, chConn);
    axR(`DCS_A_SW, 32'h0a, 2'h0);
    far.sendScon(mkImg(2'h3, 4'h0, 2'h1, 1'b1), 4'h1);
    chk("set_configuration_transfer break", 32'h0, chConn);
    far.chanPulse(2'h1, 1'b0);
    far.sysRst();
    chk("rst break", 32'h0, chConn);
    axR(`DCS_A_CCR, 32'h13c, 2'h0);
    // one channel bit only: no switching, so no busy
    far.sendScon(mkImg(2'h1, 4'h0, 2'h1, 1'b1), 4'h2);
    clrSeen <= 1'b1;
    far.chanPulse(2'h1, 1'b0);
    clrSeen <= 1'b0;
    far.chanPulse(2'h1, 1'b0);
    far.chanPulse(2'h2, 1'b0);
    chk("single busy", 32'h0, seen[5:2]);
    for (int k = 0; k < 3; k++) begin
      e0 = elcCnt;
      evPins[k] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk("event elc", e0 + 1, elcCnt);
    end
    chk("sense thm", 32'h1, senseByte4[`DCS_SNS_THM]);
    axW(`DCS_A_MASK, 32'h3f);
    axR(`DCS_A_MASK, 32'h3f, 2'h0);
    chk("irq on", 32'h1, irq);
    axR(`DCS_A_STS, 32'h3f, 2'h0);
    repeat (2) @(posedge ref_clk);
    chk("irq off", 32'h0, irq);
    axW(`DCS_A_MASK, 32'h0);
    evPins <= 3'h0;
    repeat (6) @(posedge ref_clk);
    evPins <= 3'h1;
    repeat (6) @(posedge ref_clk);
    chk("irq masked", 32'h0, irq);
    axW(`DCS_A_MASK, 32'h2);
    chk("irq unmasked", 32'h1, irq);
    testDone();
  end
endmodule : dcs_ctl_tb
bind dcs_ctl dcs_ctl_checker u_chk (.*);
